// file: logic/usf_config.sv
// Configuration registers and decoders of the serial frame and baud block.
`timescale 1ns/1ps
`default_nettype none
module usf_config
  import usf_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Debug and receive sources.
  input wire logic debug_halted,
  input wire logic rxd_in,
  input wire logic ir_event_in,
  // Auto-baud measurement.
  input wire logic [7:0] bitpair_count,
  input wire logic bitpair_valid,
  // Outputs to the datapaths.
  output usf_cfg_t cfg,
  output logic baud_load,
  output logic core_run,
  output logic rx_selected,
  output logic autobaud_ok,
  output logic autobaud_err
);

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  logic [1:0] comm_mode_q;
  logic multiproc_q;
  logic [1:0] rx_mode_q;
  logic [1:0] parity_q;
  logic stop_bit_count_q;
  logic [2:0] character_width_q;
  logic spi_bit_order_q;
  logic spi_clock_phase_q;
  logic [15:0] baud_q;
  logic [1:0] autobaud_tolerance_q;
  logic run_in_debug_q;
  logic infrared_event_input_enable_q;
  logic [7:0] tx_pulse_length_q;

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  logic [3:0] idx;
  logic req;
  logic wr_go;
  logic [7:0] wbyte;
  logic word_aligned;

  assign word_aligned = (avs_address[1:0] == 2'b00);
  assign idx = avs_address[5:2];
  assign req = (avs_read | avs_write) & avs_waitrequest;
  assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0] & word_aligned;
  assign wbyte = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (req) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      multiproc_q <= RST_BYTE[POS_MULTIPROC];
      rx_mode_q <= RST_BYTE[POS_RX_MODE +: 2];
    end else if (wr_go && idx == IDX_RX_CONTROL) begin
      multiproc_q <= wbyte[POS_MULTIPROC];
      rx_mode_q <= wbyte[POS_RX_MODE +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      comm_mode_q <= RST_FRAME_FORMAT[POS_COMM_MODE +: 2];
      parity_q <= RST_FRAME_FORMAT[POS_PARITY +: 2];
      stop_bit_count_q <= RST_FRAME_FORMAT[POS_STOP_BITS];
      character_width_q <= RST_FRAME_FORMAT[POS_CHAR_WIDTH +: 3];
      spi_bit_order_q <= RST_SPI_FRAME[POS_SPI_ORDER];
      spi_clock_phase_q <= RST_SPI_FRAME[POS_SPI_PHASE];
    end else if (wr_go && idx == IDX_FRAME_FORMAT) begin
      comm_mode_q <= wbyte[POS_COMM_MODE +: 2];
      if (wbyte[POS_COMM_MODE +: 2] == CM_HOST_SPI) begin
        spi_bit_order_q <= wbyte[POS_SPI_ORDER];
        spi_clock_phase_q <= wbyte[POS_SPI_PHASE];
      end else begin
        parity_q <= wbyte[POS_PARITY +: 2];
        stop_bit_count_q <= wbyte[POS_STOP_BITS];
        character_width_q <= wbyte[POS_CHAR_WIDTH +: 3];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      baud_q <= RST_BAUD;
    end else if (wr_go && idx == IDX_BAUD_LOW) begin
      baud_q[7:0] <= wbyte;
    end else if (wr_go && idx == IDX_BAUD_HIGH) begin
      baud_q[15:8] <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      baud_load <= 1'b0;
    end else begin
      baud_load <= wr_go && (idx == IDX_BAUD_LOW || idx == IDX_BAUD_HIGH);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      autobaud_tolerance_q <= RST_BYTE[POS_AB_WINDOW +: 2];
      run_in_debug_q <= RST_BYTE[POS_RUN_DEBUG];
      infrared_event_input_enable_q <= RST_BYTE[POS_IR_EVENT_EN];
      tx_pulse_length_q <= RST_BYTE;
    end else if (wr_go) begin
      case (idx)
        IDX_AUTOBAUD_WINDOW: begin
          autobaud_tolerance_q <= wbyte[POS_AB_WINDOW +: 2];
        end
        IDX_DEBUG_HALT: begin
          run_in_debug_q <= wbyte[POS_RUN_DEBUG];
        end
        IDX_IR_EVENT: begin
          infrared_event_input_enable_q <= wbyte[POS_IR_EVENT_EN];
        end
        IDX_IR_TX_PULSE: begin
          tx_pulse_length_q <= wbyte;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      IDX_RX_CONTROL: begin
        rd_byte[POS_MULTIPROC] = multiproc_q;
        rd_byte[POS_RX_MODE +: 2] = rx_mode_q;
      end
      IDX_FRAME_FORMAT: begin
        rd_byte[POS_COMM_MODE +: 2] = comm_mode_q;
        if (comm_mode_q == CM_HOST_SPI) begin
          rd_byte[POS_SPI_ORDER] = spi_bit_order_q;
          rd_byte[POS_SPI_PHASE] = spi_clock_phase_q;
        end else begin
          rd_byte[POS_PARITY +: 2] = parity_q;
          rd_byte[POS_STOP_BITS] = stop_bit_count_q;
          rd_byte[POS_CHAR_WIDTH +: 3] = character_width_q;
        end
      end
      IDX_BAUD_LOW: begin
        rd_byte = baud_q[7:0];
      end
      IDX_BAUD_HIGH: begin
        rd_byte = baud_q[15:8];
      end
      IDX_AUTOBAUD_WINDOW: begin
        rd_byte[POS_AB_WINDOW +: 2] = autobaud_tolerance_q;
      end
      IDX_DEBUG_HALT: begin
        rd_byte[POS_RUN_DEBUG] = run_in_debug_q;
      end
      IDX_IR_EVENT: begin
        rd_byte[POS_IR_EVENT_EN] = infrared_event_input_enable_q;
      end
      IDX_IR_TX_PULSE: begin
        rd_byte = tx_pulse_length_q;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    if (!word_aligned) begin
      rd_byte = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------
  usf_cfg_t cfg_d;

  always_comb begin
    cfg_d = '0;
    cfg_d.comm_mode = usf_comm_mode_t'(comm_mode_q);
    cfg_d.multiproc_mode_enable = multiproc_q;
    cfg_d.rx_mode = usf_rx_mode_t'(rx_mode_q);
    cfg_d.baud_divisor = baud_q;
    cfg_d.tx_pulse_length = tx_pulse_length_q;
    cfg_d.lin_constrained_autobaud = (rx_mode_q == RM_LIN_AUTO);
    if (comm_mode_q == CM_HOST_SPI) begin
      cfg_d.spi_lsb_first = spi_bit_order_q;
      cfg_d.spi_sample_trailing = spi_clock_phase_q;
      cfg_d.data_bits = 4'h8;
      cfg_d.tx_stop_bits = 2'd0;
    end else begin
      case (parity_q)
        2'b10: begin
          cfg_d.parity_enable = 1'b1;
        end
        2'b11: begin
          cfg_d.parity_enable = 1'b1;
          cfg_d.parity_odd = 1'b1;
        end
        2'b01: begin
          cfg_d.parity_reserved = 1'b1;
        end
        default: begin
          cfg_d.parity_enable = 1'b0;
        end
      endcase
      cfg_d.tx_stop_bits = stop_bit_count_q ? 2'd2 : 2'd1;
      case (character_width_q)
        3'h0: cfg_d.data_bits = 4'h5;
        3'h1: cfg_d.data_bits = 4'h6;
        3'h2: cfg_d.data_bits = 4'h7;
        3'h3: cfg_d.data_bits = 4'h8;
        3'h6: begin
          cfg_d.data_bits = 4'h9;
          cfg_d.nine_bit_low_first = 1'b1;
        end
        3'h7: begin
          cfg_d.data_bits = 4'h9;
          cfg_d.nine_bit_high_first = 1'b1;
        end
        default: begin
          cfg_d.data_bits = 4'h8;
          cfg_d.char_reserved = 1'b1;
        end
      endcase
    end
    if (tx_pulse_length_q == PULSE_THREE_SIXTEENTHS) begin
      cfg_d.ir_coding = IR_THREE_SIXTEENTHS;
    end else if (tx_pulse_length_q == PULSE_PASS_THROUGH) begin
      cfg_d.ir_coding = IR_PASS_THROUGH;
    end else begin
      cfg_d.ir_coding = IR_FIXED;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg <= cfg_d;
    end
  end

  // ----------------------------------------------------------------------
  // Debug halt and receive source
  // ----------------------------------------------------------------------
  logic run_d;

  assign run_d = run_in_debug_q | ~debug_halted;

  always_ff @(posedge clk) begin
    if (rst) begin
      core_run <= 1'b1;
    end else begin
      core_run <= run_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_selected <= 1'b1;
    end else if (infrared_event_input_enable_q) begin
      rx_selected <= run_d ? ir_event_in : 1'b1;
    end else begin
      rx_selected <= rxd_in;
    end
  end

  // ----------------------------------------------------------------------
  // Auto-baud window check
  // ----------------------------------------------------------------------
  logic [3:0] tol;
  logic [7:0] dev;
  logic in_window;

  always_comb begin
    case (autobaud_tolerance_q)
      2'b00: tol = TOL_W0;
      2'b01: tol = TOL_W1;
      2'b10: tol = TOL_W2;
      2'b11: tol = TOL_W3;
      default: tol = TOL_W0;
    endcase
  end

  assign dev = (bitpair_count >= NOMINAL_PAIR) ? 8'(bitpair_count - NOMINAL_PAIR)
                                               : 8'(NOMINAL_PAIR - bitpair_count);
  assign in_window = (dev <= {4'h0, tol});

  always_ff @(posedge clk) begin
    if (rst) begin
      autobaud_ok <= 1'b0;
      autobaud_err <= 1'b0;
    end else begin
      autobaud_ok <= bitpair_valid & run_d & (rx_mode_q == RM_LIN_AUTO) & in_window;
      autobaud_err <= bitpair_valid & run_d & (rx_mode_q == RM_LIN_AUTO) & ~in_window;
    end
  end

endmodule
`default_nettype wire

// file: shared/usf_pkg.sv
// Package with register map, field layout, reset values and types of the serial frame and baud configuration block.
package usf_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [3:0] IDX_RX_CONTROL = 4'h6;
  localparam logic [3:0] IDX_FRAME_FORMAT = 4'h7;
  localparam logic [3:0] IDX_BAUD_LOW = 4'h8;
  localparam logic [3:0] IDX_BAUD_HIGH = 4'h9;
  localparam logic [3:0] IDX_AUTOBAUD_WINDOW = 4'ha;
  localparam logic [3:0] IDX_DEBUG_HALT = 4'hb;
  localparam logic [3:0] IDX_IR_EVENT = 4'hc;
  localparam logic [3:0] IDX_IR_TX_PULSE = 4'hd;

  // Field positions.
  localparam int POS_MULTIPROC = 0;
  localparam int POS_RX_MODE = 1;
  localparam int POS_COMM_MODE = 6;
  localparam int POS_PARITY = 4;
  localparam int POS_STOP_BITS = 3;
  localparam int POS_CHAR_WIDTH = 0;
  localparam int POS_SPI_ORDER = 2;
  localparam int POS_SPI_PHASE = 1;
  localparam int POS_AB_WINDOW = 6;
  localparam int POS_RUN_DEBUG = 0;
  localparam int POS_IR_EVENT_EN = 0;

  // Reset values.
  localparam logic [7:0] RST_FRAME_FORMAT = 8'h03;
  localparam logic [7:0] RST_SPI_FRAME = 8'h00;
  localparam logic [15:0] RST_BAUD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Auto-baud figures: samples per bit and nominal samples per bit pair.
  localparam int SAMPLES_PER_BIT = 16;
  localparam logic [7:0] NOMINAL_PAIR = 8'(2 * SAMPLES_PER_BIT);
  localparam logic [3:0] TOL_W0 = 4'h6;
  localparam logic [3:0] TOL_W1 = 4'h5;
  localparam logic [3:0] TOL_W2 = 4'h7;
  localparam logic [3:0] TOL_W3 = 4'h8;

  // Infrared transmit pulse codes.
  localparam logic [7:0] PULSE_THREE_SIXTEENTHS = 8'h00;
  localparam logic [7:0] PULSE_PASS_THROUGH = 8'hff;

  typedef enum logic [1:0] {
    CM_ASYNC = 2'b00,
    CM_SYNC = 2'b01,
    CM_INFRARED = 2'b10,
    CM_HOST_SPI = 2'b11
  } usf_comm_mode_t;

  typedef enum logic [1:0] {
    RM_NORMAL = 2'b00,
    RM_DOUBLE = 2'b01,
    RM_GENERIC_AUTO = 2'b10,
    RM_LIN_AUTO = 2'b11
  } usf_rx_mode_t;

  typedef enum logic [1:0] {
    IR_THREE_SIXTEENTHS = 2'b00,
    IR_FIXED = 2'b01,
    IR_PASS_THROUGH = 2'b10
  } usf_ir_coding_t;

  // Decoded configuration handed to the transmit and receive datapaths.
  typedef struct packed {
    usf_comm_mode_t comm_mode;
    logic multiproc_mode_enable;
    usf_rx_mode_t rx_mode;
    logic parity_enable;
    logic parity_odd;
    logic parity_reserved;
    logic [1:0] tx_stop_bits;
    logic [3:0] data_bits;
    logic nine_bit_low_first;
    logic nine_bit_high_first;
    logic char_reserved;
    logic spi_lsb_first;
    logic spi_sample_trailing;
    logic [15:0] baud_divisor;
    logic lin_constrained_autobaud;
    usf_ir_coding_t ir_coding;
    logic [7:0] tx_pulse_length;
  } usf_cfg_t;

endpackage

// file: testbench/usf_config_props.sv
// Checker for the bus handshake, baud reload, auto-baud and decoded configuration.
`timescale 1ns/1ps
`default_nettype none
module usf_config_props
  import usf_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus.
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Debug and auto-baud.
  input wire logic debug_halted,
  input wire logic [7:0] bitpair_count,
  input wire logic bitpair_valid,
  // Watched outputs.
  input wire usf_cfg_t cfg,
  input wire logic baud_load,
  input wire logic core_run,
  input wire logic autobaud_ok,
  input wire logic autobaud_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic baud_wr;
  assign baud_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[1:0] == 2'h0
                   && avs_address[5:3] == 3'h4;
  a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_baud_reload: assert property (baud_wr |=> baud_load)
    else $error("baud write without reload pulse");
  a_baud_cause: assert property (baud_load |-> $past(baud_wr))
    else $error("reload pulse without baud write");
  a_spi_view: assert property (cfg.comm_mode == CM_HOST_SPI |-> cfg.data_bits == 4'h8 && cfg.tx_stop_bits == 2'h0)
    else $error("frame fields active in SPI view");
  a_halt_free: assert property (!$past(debug_halted) |-> core_run)
    else $error("core stopped while not halted");
  a_ab_ok_window: assert property (autobaud_ok |-> $past(bitpair_valid) && !autobaud_err
    && $past(bitpair_count) >= 8'h18 && $past(bitpair_count) <= 8'h28)
    else $error("pair accepted outside widest window");
  a_ab_err_window: assert property (autobaud_err |-> $past(bitpair_valid)
    && ($past(bitpair_count) < 8'h1b || $past(bitpair_count) > 8'h25))
    else $error("pair refused inside narrowest window");
  a_ab_answer: assert property (bitpair_valid && cfg.lin_constrained_autobaud && core_run
    |=> autobaud_ok || autobaud_err)
    else $error("measured pair left unanswered");
  a_ab_lin_only: assert property (autobaud_ok || autobaud_err |-> $past(cfg.lin_constrained_autobaud && core_run))
    else $error("auto-baud answer outside LIN mode");
endmodule
bind usf_config usf_config_props chk_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .debug_halted(debug_halted), .bitpair_count(bitpair_count), .bitpair_valid(bitpair_valid), .cfg(cfg),
  .baud_load(baud_load), .core_run(core_run), .autobaud_ok(autobaud_ok), .autobaud_err(autobaud_err));
`default_nettype wire

// file: testbench/usf_config_tb_top.sv
// Self-checking testbench of the frame and baud configuration block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %0h not %0h", $time, (a), (b)); end end
module usf_config_tb_top
  import usf_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic debug_halted = 1'b0;
  wire logic rxd, ir_ev, pv;
  wire logic [7:0] pc;
  usf_cfg_t cfg;
  logic baud_load, core_run, rx_selected, autobaud_ok, autobaud_err, load_seen;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  usf_peer_model peer_u (.clk(clk), .rxd(rxd), .ir_event(ir_ev), .pair_count(pc), .pair_valid(pv));
  usf_config dut_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .debug_halted(debug_halted), .rxd_in(rxd), .ir_event_in(ir_ev),
    .bitpair_count(pc), .bitpair_valid(pv), .cfg(cfg), .baud_load(baud_load), .core_run(core_run),
    .rx_selected(rx_selected), .autobaud_ok(autobaud_ok), .autobaud_err(autobaud_err));
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end
  task automatic bus(input logic wr, input logic [3:0] i, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    avs_address <= {i, 2'h0};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, i, d, q);
    @(posedge clk);
    load_seen = baud_load;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] i, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, i, 8'h00, q);
    `CHK(q, e)
  endtask
  task automatic pair(input logic [7:0] c, input logic eo, input logic ee);
    peer_u.send_pair(c);
    @(posedge clk);
    `CHK(autobaud_ok, eo)
    `CHK(autobaud_err, ee)
  endtask
  task automatic t_reset;
    rd_chk(IDX_FRAME_FORMAT, 8'h03);
    `CHK(cfg.data_bits, 4'h8)
    `CHK(cfg.tx_stop_bits, 2'h1)
    for (int k = 8; k < 14; k++) rd_chk(4'(k), 8'h00);
    avs_byteenable <= 4'h0;
    wr(IDX_IR_TX_PULSE, 8'h5a);
    avs_byteenable <= 4'hf;
    rd_chk(IDX_IR_TX_PULSE, 8'h00);
    wr(4'he, 8'h5a);
    rd_chk(4'he, 8'h00);
  endtask
  task automatic t_frame;
    logic [1:0] p, m;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      p = 2'(k);
      m = (k == 3) ? 2'h0 : p;
      v = {m, p, p[0], 3'h3};
      wr(IDX_FRAME_FORMAT, v);
      `CHK(cfg.comm_mode, usf_comm_mode_t'(m))
      `CHK({cfg.parity_enable, cfg.parity_odd, cfg.parity_reserved}, {p[1], p == 2'h3, p == 2'h1})
      `CHK(cfg.tx_stop_bits, p[0] ? 2'h2 : 2'h1)
      rd_chk(IDX_FRAME_FORMAT, v);
    end
    for (int k = 0; k < 8; k++) begin
      wr(IDX_FRAME_FORMAT, 8'(k));
      `CHK(cfg.data_bits, 4'(k < 4 ? 5 + k : k < 6 ? 8 : 9))
      `CHK({cfg.char_reserved, cfg.nine_bit_low_first, cfg.nine_bit_high_first}, {k == 4 || k == 5, k == 6, k == 7})
    end
  endtask
  task automatic t_spi;
    wr(IDX_FRAME_FORMAT, 8'hff);
    `CHK(cfg.comm_mode, CM_HOST_SPI)
    `CHK({cfg.spi_lsb_first, cfg.spi_sample_trailing}, 2'h3)
    rd_chk(IDX_FRAME_FORMAT, 8'hc6);
    wr(IDX_FRAME_FORMAT, 8'h2e);
    rd_chk(IDX_FRAME_FORMAT, 8'h2e);
    wr(IDX_FRAME_FORMAT, 8'hc0);
    `CHK({cfg.spi_lsb_first, cfg.spi_sample_trailing}, 2'h0)
    rd_chk(IDX_FRAME_FORMAT, 8'hc0);
    wr(IDX_FRAME_FORMAT, 8'h03);
  endtask
  task automatic t_baud;
    wr(IDX_BAUD_LOW, 8'h34);
    `CHK(load_seen, 1'b1)
    wr(IDX_BAUD_HIGH, 8'h12);
    `CHK(load_seen, 1'b1)
    `CHK(cfg.baud_divisor, 16'h1234)
    rd_chk(IDX_BAUD_LOW, 8'h34);
    rd_chk(IDX_BAUD_HIGH, 8'h12);
    wr(IDX_IR_TX_PULSE, 8'h01);
    `CHK(load_seen, 1'b0)
  endtask
  task automatic t_autobaud;
    logic [7:0] t;
    wr(IDX_RX_CONTROL, 8'h07);
    `CHK(cfg.multiproc_mode_enable, 1'b1)
    `CHK(cfg.lin_constrained_autobaud, 1'b1)
    for (int k = 0; k < 4; k++) begin
      t = (k == 0) ? 8'h06 : (k == 1) ? 8'h05 : (k == 2) ? 8'h07 : 8'h08;
      wr(IDX_AUTOBAUD_WINDOW, {2'(k), 6'h00});
      pair(8'h20 + t, 1'b1, 1'b0);
      pair(8'h21 + t, 1'b0, 1'b1);
      pair(8'h20 - t, 1'b1, 1'b0);
      pair(8'h1f - t, 1'b0, 1'b1);
    end
    wr(IDX_RX_CONTROL, 8'h00);
    `CHK(cfg.multiproc_mode_enable, 1'b0)
    pair(8'h20, 1'b0, 1'b0);
    wr(IDX_RX_CONTROL, 8'h04);
    `CHK(cfg.rx_mode, RM_GENERIC_AUTO)
    `CHK(cfg.lin_constrained_autobaud, 1'b0)
    pair(8'h20, 1'b0, 1'b0);
  endtask
  task automatic t_debug;
    wr(IDX_RX_CONTROL, 8'h06);
    @(posedge clk);
    debug_halted <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(core_run, 1'b0)
    pair(8'h20, 1'b0, 1'b0);
    wr(IDX_DEBUG_HALT, 8'h01);
    `CHK(core_run, 1'b1)
    pair(8'h20, 1'b1, 1'b0);
    debug_halted <= 1'b0;
    wr(IDX_DEBUG_HALT, 8'h00);
  endtask
  task automatic t_ir;
    peer_u.drive_lines(1'b0, 1'b1);
    repeat (2) @(posedge clk);
    `CHK(rx_selected, 1'b0)
    wr(IDX_IR_EVENT, 8'h01);
    `CHK(rx_selected, 1'b1)
    peer_u.drive_lines(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(rx_selected, 1'b0)
    debug_halted <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK(rx_selected, 1'b1)
    debug_halted <= 1'b0;
    wr(IDX_IR_EVENT, 8'h00);
    `CHK(rx_selected, 1'b1)
  endtask
  task automatic t_pulse;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'h05 : (k == 2) ? 8'hfe : 8'hff;
      wr(IDX_IR_TX_PULSE, v);
      `CHK(cfg.ir_coding, (k == 0) ? IR_THREE_SIXTEENTHS : (k == 3) ? IR_PASS_THROUGH : IR_FIXED)
      rd_chk(IDX_IR_TX_PULSE, v);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_frame();
    t_spi();
    t_baud();
    t_autobaud();
    t_debug();
    t_ir();
    t_pulse();
    stop_test();
  end
endmodule
`default_nettype wire

// file: testbench/usf_peer_model.sv
// Serial peer model that drives the receive lines and reports measured bit pairs.
`timescale 1ns/1ps
`default_nettype none
module usf_peer_model (
  // Clock.
  input wire logic clk,
  // Lines and measurement.
  output logic rxd,
  output logic ir_event,
  output logic [7:0] pair_count,
  output logic pair_valid
);
  initial begin
    rxd = 1'b1;
    ir_event = 1'b1;
    pair_count = 8'h00;
    pair_valid = 1'b0;
  end
  // Sets both receive sources.
  task automatic drive_lines(input logic r, input logic e);
    @(posedge clk);
    rxd <= r;
    ir_event <= e;
  endtask
  // Reports one bit pair; matched rates give 32.
  task automatic send_pair(input logic [7:0] c);
    @(posedge clk);
    pair_count <= c;
    pair_valid <= 1'b1;
    @(posedge clk);
    pair_valid <= 1'b0;
    pair_count <= ~c;
  endtask
endmodule
`default_nettype wire
